// >>> src/isc_pkg.sv
// Constants for the interrupt flag, enable and status block
package isc_pkg;
   // ==========================================================
   // Sizes
   localparam int FLAG_REGS = 8;
   localparam int REG_W = 32;
   localparam int ADDR_W = 12;
   localparam int PRIO_W = 3;
   localparam int NUM_W = 8;
   localparam int EVT_W = 3;
   // ==========================================================
   // Byte offsets and block numbers (address bits 11:5)
   localparam logic [11:0] OFF_CONTROL = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_RELOAD = 12'h008;
   localparam logic [11:0] OFF_EVT_STATUS = 12'h00c;
   localparam logic [11:0] OFF_EVT_MASK = 12'h010;
   localparam logic [6:0] BLK_FLAG = 7'h08;
   localparam logic [6:0] BLK_ENABLE = 7'h09;
   // ==========================================================
   // Field positions
   localparam int CTL_MULTI_BIT = 12;
   localparam int CTL_TRIG_LSB = 8;
   localparam int STAT_LEVEL_LSB = 8;
   localparam int EVT_PRESENT = 0;
   localparam int EVT_PROX = 1;
   localparam int EVT_SERVICE = 2;
   // ==========================================================
   // Reset values and answers
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [2:0] PRIO_OFF = 3'h0;
endpackage

// >>> src/interrupt_pick.sv
// Picks the highest-priority pending source, lowest number on a tie
`timescale 1ns/1ps
`default_nettype none
module interrupt_pick #(
   parameter int NUM_SRC = 256
) (
   input wire logic [NUM_SRC-1:0] pending,
   input wire logic [NUM_SRC*isc_pkg::PRIO_W-1:0] priority_flat,
   output logic pick_any,
   output logic [isc_pkg::NUM_W-1:0] pick_number,
   output logic [isc_pkg::PRIO_W-1:0] pick_level
);
   always_comb
   begin
      pick_any = 1'b0;
      pick_number = '0;
      pick_level = isc_pkg::PRIO_OFF;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (pending[i] && (!pick_any ||
             priority_flat[i*isc_pkg::PRIO_W +: isc_pkg::PRIO_W] > pick_level))
         begin
            pick_any = 1'b1;
            pick_number = isc_pkg::NUM_W'(i);
            pick_level = priority_flat[i*isc_pkg::PRIO_W +: isc_pkg::PRIO_W];
         end
      end
   end
endmodule
`default_nettype wire

// >>> src/interrupt_status_flag_enable.sv
// Flag, enable, status and proximity reload registers on AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module interrupt_status_flag_enable #(
   parameter int NUM_SRC = isc_pkg::FLAG_REGS * isc_pkg::REG_W
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [isc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [isc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_SRC-1:0] source_request,
   input wire logic [NUM_SRC*isc_pkg::PRIO_W-1:0] source_priority_setting,
   input wire logic service_ack,
   input wire logic [isc_pkg::NUM_W-1:0] service_number,
   output logic request_valid,
   output logic [isc_pkg::NUM_W-1:0] request_vector_number,
   output logic [isc_pkg::PRIO_W-1:0] request_level,
   output logic multi_vector_select,
   output logic proximity_load,
   output logic [31:0] proximity_timer_reload,
   output logic irq
);
   // ==========================================================
   // Storage
   logic [31:0] flag_word [isc_pkg::FLAG_REGS];
   logic [31:0] enable_word [isc_pkg::FLAG_REGS];
   logic [NUM_SRC-1:0] all_flag;
   logic [NUM_SRC-1:0] all_enable;
   logic [NUM_SRC-1:0] pending;
   logic [isc_pkg::PRIO_W-1:0] proximity_trigger_level;
   logic [isc_pkg::PRIO_W-1:0] presented_priority_level;
   logic [isc_pkg::NUM_W-1:0] last_serviced_request;
   logic [isc_pkg::NUM_W-1:0] request_number;
   logic [isc_pkg::EVT_W-1:0] evt_status;
   logic [isc_pkg::EVT_W-1:0] evt_mask;
   logic [isc_pkg::EVT_W-1:0] evt_set;
   logic pick_any;
   logic [isc_pkg::NUM_W-1:0] pick_number;
   logic [isc_pkg::PRIO_W-1:0] pick_level;
   logic new_present;
   logic prox_fire;
   // ==========================================================
   // Bus state
   logic aw_held;
   logic w_held;
   logic [isc_pkg::ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_fire;
   logic [isc_pkg::ADDR_W-1:0] rd_addr;
   logic [31:0] next_rdata;
   logic next_rd_ok;
   logic wr_ok;
   logic [31:0] status_word;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] result;
      result = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            result[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return result;
   endfunction

   function automatic logic mapped(input logic [isc_pkg::ADDR_W-1:0] a);
      return a == isc_pkg::OFF_CONTROL || a == isc_pkg::OFF_STATUS ||
             a == isc_pkg::OFF_RELOAD || a == isc_pkg::OFF_EVT_STATUS ||
             a == isc_pkg::OFF_EVT_MASK || a[11:5] == isc_pkg::BLK_FLAG ||
             a[11:5] == isc_pkg::BLK_ENABLE;
   endfunction

   assign wr_fire = aw_held && w_held;
   assign wr_ok = mapped(wr_addr) && wr_addr[1:0] == 2'h0;
   assign status_word = {21'h000000, presented_priority_level, last_serviced_request};

   // ==========================================================
   // Write channel
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_addr <= '0;
         wr_data <= isc_pkg::RESET_WORD;
         wr_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= isc_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         else if (!aw_held && !s_axi_bvalid)
         begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         else if (!w_held && !s_axi_bvalid)
         begin
            s_axi_wready <= 1'b1;
         end
         if (wr_fire)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? isc_pkg::RESP_OKAY : isc_pkg::RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Control, reload, event mask
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         multi_vector_select <= 1'b0;
         proximity_trigger_level <= isc_pkg::PRIO_OFF;
         proximity_timer_reload <= isc_pkg::RESET_WORD;
         evt_mask <= '0;
      end
      else if (wr_fire)
      begin
         if (wr_addr == isc_pkg::OFF_CONTROL && wr_strb[1])
         begin
            multi_vector_select <= wr_data[isc_pkg::CTL_MULTI_BIT];
            proximity_trigger_level <= wr_data[isc_pkg::CTL_TRIG_LSB +: isc_pkg::PRIO_W];
         end
         if (wr_addr == isc_pkg::OFF_RELOAD)
         begin
            proximity_timer_reload <= merge(proximity_timer_reload, wr_data, wr_strb);
         end
         if (wr_addr == isc_pkg::OFF_EVT_MASK && wr_strb[0])
         begin
            evt_mask <= wr_data[isc_pkg::EVT_W-1:0];
         end
      end
   end

   // ==========================================================
   // Flag and enable words
   genvar g;
   generate
      for (g = 0; g < isc_pkg::FLAG_REGS; g++)
      begin : g_word
         logic wr_flag;
         logic wr_enable;
         assign wr_flag = wr_fire && wr_addr[11:5] == isc_pkg::BLK_FLAG && wr_addr[4:2] == g;
         assign wr_enable = wr_fire && wr_addr[11:5] == isc_pkg::BLK_ENABLE &&
                            wr_addr[4:2] == g;
         always_ff @(posedge ref_clk or posedge reset)
         begin
            if (reset)
            begin
               flag_word[g] <= isc_pkg::RESET_WORD;
               enable_word[g] <= isc_pkg::RESET_WORD;
            end
            else
            begin
               // Source request wins over a software clear
               flag_word[g] <= (wr_flag ? merge(flag_word[g], wr_data, wr_strb) : flag_word[g])
                               | source_request[g*32 +: 32];
               if (wr_enable)
               begin
                  enable_word[g] <= merge(enable_word[g], wr_data, wr_strb);
               end
            end
         end
         assign all_flag[g*32 +: 32] = flag_word[g];
         assign all_enable[g*32 +: 32] = enable_word[g];
      end
      for (g = 0; g < NUM_SRC; g++)
      begin : g_src
         assign pending[g] = all_flag[g] && all_enable[g] &&
            source_priority_setting[g*isc_pkg::PRIO_W +: isc_pkg::PRIO_W] != isc_pkg::PRIO_OFF;
      end
   endgenerate

   interrupt_pick #(.NUM_SRC(NUM_SRC)) u_pick (
      .pending(pending),
      .priority_flat(source_priority_setting),
      .pick_any(pick_any),
      .pick_number(pick_number),
      .pick_level(pick_level)
   );

   // ==========================================================
   // Presentation to the core
   assign new_present = pick_any && (!request_valid || pick_number != request_number);
   assign prox_fire = new_present && proximity_trigger_level != isc_pkg::PRIO_OFF &&
                      pick_level <= proximity_trigger_level;

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         request_valid <= 1'b0;
         request_number <= '0;
         request_vector_number <= '0;
         request_level <= isc_pkg::PRIO_OFF;
         presented_priority_level <= isc_pkg::PRIO_OFF;
         proximity_load <= 1'b0;
      end
      else
      begin
         request_valid <= pick_any;
         request_number <= pick_number;
         request_level <= pick_level;
         // Single-vector mode sends every request to vector 0
         request_vector_number <= multi_vector_select ? pick_number : '0;
         proximity_load <= prox_fire;
         if (new_present)
         begin
            presented_priority_level <= pick_level;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         last_serviced_request <= '0;
      end
      else if (service_ack)
      begin
         last_serviced_request <= service_number;
      end
   end

   // ==========================================================
   // Event status and interrupt output
   assign evt_set = {service_ack, prox_fire, new_present};

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         evt_status <= '0;
         irq <= 1'b0;
      end
      else
      begin
         if (wr_fire && wr_addr == isc_pkg::OFF_EVT_STATUS && wr_strb[0])
         begin
            evt_status <= (evt_status & ~wr_data[isc_pkg::EVT_W-1:0]) | evt_set;
         end
         else
         begin
            evt_status <= evt_status | evt_set;
         end
         irq <= |(evt_status & evt_mask);
      end
   end

   // ==========================================================
   // Read channel
   always_comb
   begin
      next_rdata = isc_pkg::RESET_WORD;
      next_rd_ok = mapped(s_axi_araddr) && s_axi_araddr[1:0] == 2'h0;
      if (s_axi_araddr[11:5] == isc_pkg::BLK_FLAG)
      begin
         next_rdata = flag_word[s_axi_araddr[4:2]];
      end
      else if (s_axi_araddr[11:5] == isc_pkg::BLK_ENABLE)
      begin
         next_rdata = enable_word[s_axi_araddr[4:2]];
      end
      else
      begin
         case (s_axi_araddr)
            isc_pkg::OFF_CONTROL: next_rdata = {19'h00000, multi_vector_select, 1'b0,
                                                proximity_trigger_level, 8'h00};
            isc_pkg::OFF_STATUS: next_rdata = status_word;
            isc_pkg::OFF_RELOAD: next_rdata = proximity_timer_reload;
            isc_pkg::OFF_EVT_STATUS: next_rdata = {29'h00000000, evt_status};
            isc_pkg::OFF_EVT_MASK: next_rdata = {29'h00000000, evt_mask};
            default: next_rdata = isc_pkg::RESET_WORD;
         endcase
      end
      if (!next_rd_ok)
      begin
         next_rdata = isc_pkg::RESET_WORD;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= isc_pkg::RESET_WORD;
         s_axi_rresp <= isc_pkg::RESP_OKAY;
         rd_addr <= '0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rd_ok ? isc_pkg::RESP_OKAY : isc_pkg::RESP_SLVERR;
         rd_addr <= s_axi_araddr;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
      else if (!s_axi_rvalid)
      begin
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================================
   // Checks
   sequence s_status_read;
      s_axi_rvalid && rd_addr == isc_pkg::OFF_STATUS;
   endsequence
   sequence s_reload_write;
      wr_fire && wr_addr == isc_pkg::OFF_RELOAD && wr_strb == 4'hf;
   endsequence
   sequence s_single_mode;
      !multi_vector_select ##1 request_valid;
   endsequence

   a_status_upper_zero: assert property (@(posedge ref_clk) disable iff (reset)
      s_status_read |-> s_axi_rdata[31:11] == 21'h000000)
      else $error("status upper bits not zero");
   a_reload_written: assert property (@(posedge ref_clk) disable iff (reset)
      s_reload_write |=> proximity_timer_reload == $past(wr_data))
      else $error("reload value not stored");
   a_flag_set_wins: assert property (@(posedge ref_clk) disable iff (reset)
      |source_request |=> (all_flag & $past(source_request)) == $past(source_request))
      else $error("requested flag not set");
   a_pick_is_pending: assert property (@(posedge ref_clk) disable iff (reset)
      pick_any |-> all_flag[pick_number] && all_enable[pick_number])
      else $error("picked source lacks flag or enable");
   a_pick_prio_nonzero: assert property (@(posedge ref_clk) disable iff (reset)
      pick_any |-> source_priority_setting[pick_number*isc_pkg::PRIO_W +: isc_pkg::PRIO_W]
                   != isc_pkg::PRIO_OFF)
      else $error("source with priority zero picked");
   a_prox_threshold: assert property (@(posedge ref_clk) disable iff (reset)
      proximity_load |-> $past(proximity_trigger_level) != isc_pkg::PRIO_OFF &&
                         $past(pick_level) <= $past(proximity_trigger_level))
      else $error("proximity load outside threshold");
   a_level_latched: assert property (@(posedge ref_clk) disable iff (reset)
      new_present |=> presented_priority_level == $past(pick_level) &&
                      status_word[10:8] == $past(pick_level))
      else $error("presented level not latched");
   a_serviced_number: assert property (@(posedge ref_clk) disable iff (reset)
      service_ack |=> last_serviced_request == $past(service_number) &&
                      status_word[7:0] == $past(service_number))
      else $error("serviced number not shown");
   a_single_vector: assert property (@(posedge ref_clk) disable iff (reset)
      s_single_mode |-> request_vector_number == '0)
      else $error("single mode vector not zero");
   a_irq_level: assert property (@(posedge ref_clk) disable iff (reset)
      ##1 irq == |($past(evt_status) & $past(evt_mask)))
      else $error("interrupt output mismatch");
endmodule
`default_nettype wire

// >>> sim/core_model.sv
// Behavioural processor core that services presented requests
`timescale 1ns/1ps
`default_nettype none
module core_model #(
   parameter int LATENCY = 3
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic take_enable,
   input wire logic request_valid,
   input wire logic [isc_pkg::NUM_W-1:0] request_vector_number,
   output logic service_ack,
   output logic [isc_pkg::NUM_W-1:0] service_number
);
   int wait_cnt;
   // ==========================================================
   // Service after a fixed delay; number line toggles when idle
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         wait_cnt <= 0;
         service_ack <= 1'b0;
         service_number <= 8'h00;
      end
      else
      begin
         service_ack <= 1'b0;
         service_number <= ~service_number;
         if (take_enable && request_valid)
         begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt == LATENCY)
            begin
               wait_cnt <= 0;
               service_ack <= 1'b1;
               service_number <= request_vector_number;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> sim/interrupt_status_flag_enable_tb.sv
// Register and presentation tests for the flag, enable and status block
`timescale 1ns/1ps
`default_nettype none
module interrupt_status_flag_enable_tb;
   logic ref_clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, proximity_timer_reload, rd_data;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [255:0] source_request;
   logic [767:0] source_priority_setting;
   logic service_ack, request_valid, multi_vector_select, proximity_load, irq, take_enable;
   logic [7:0] service_number, request_vector_number;
   logic [2:0] request_level;
   int error_cnt, tests_run, prox_cnt;
   interrupt_status_flag_enable i_dut (.ref_clk(ref_clk), .reset(reset),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .source_request(source_request), .source_priority_setting(source_priority_setting),
      .service_ack(service_ack), .service_number(service_number),
      .request_valid(request_valid), .request_vector_number(request_vector_number),
      .request_level(request_level), .multi_vector_select(multi_vector_select),
      .proximity_load(proximity_load), .proximity_timer_reload(proximity_timer_reload),
      .irq(irq));
   core_model i_core (.ref_clk(ref_clk), .reset(reset), .take_enable(take_enable),
      .request_valid(request_valid), .request_vector_number(request_vector_number),
      .service_ack(service_ack), .service_number(service_number));
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      if (proximity_load === 1'b1)
         prox_cnt++;
   end
   // ==========================================================
   // Helpers
   task automatic conclude();
      $display("checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
      chk("bresp", 32'h0, {30'h0, s_axi_bresp});
   endtask
   task automatic bus_read(input logic [11:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'b0;
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
   endtask
   task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
      bus_read(a);
      chk(name, exp, rd_data);
      chk("rresp", {30'h0, isc_pkg::RESP_OKAY}, {30'h0, resp});
   endtask
   task automatic pulse_src(input int i);
      @(posedge ref_clk);
      source_request[i] <= 1'b1;
      @(posedge ref_clk);
      source_request[i] <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic chk_pick(input logic v, input logic [7:0] n, input logic [2:0] l);
      chk("request_valid", {31'h0, v}, {31'h0, request_valid});
      chk("request_vector_number", {24'h0, n}, {24'h0, request_vector_number});
      chk("request_level", {29'h0, l}, {29'h0, request_level});
   endtask
   // ==========================================================
   // Watchdog
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      conclude();
   end
   // ==========================================================
   // Test sequence
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hf;
      source_request = '0;
      source_priority_setting = '0;
      source_priority_setting[17:15] = 3'h3;
      source_priority_setting[20:18] = 3'h4;
      source_priority_setting[26:24] = 3'h2;
      take_enable = 1'b0;
      {error_cnt, tests_run, prox_cnt} = '0;
      reset = 1'b1;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rd_chk("status reset", isc_pkg::OFF_STATUS, 32'h0);
      rd_chk("reload reset", isc_pkg::OFF_RELOAD, 32'h0);
      rd_chk("flag reset", 12'h11c, 32'h0);
      rd_chk("enable reset", 12'h13c, 32'h0);
      bus_write(isc_pkg::OFF_RELOAD, 32'ha5c3_0f1e);
      rd_chk("reload", isc_pkg::OFF_RELOAD, 32'ha5c3_0f1e);
      chk("reload port", 32'ha5c3_0f1e, proximity_timer_reload);
      s_axi_wstrb <= 4'h3;
      bus_write(isc_pkg::OFF_RELOAD, 32'h0000_ffff);
      s_axi_wstrb <= 4'hf;
      rd_chk("reload lanes", isc_pkg::OFF_RELOAD, 32'ha5c3_ffff);
      bus_write(isc_pkg::OFF_STATUS, 32'hffff_ffff);
      rd_chk("status write", isc_pkg::OFF_STATUS, 32'h0);
      bus_read(12'hffc);
      chk("unmapped resp", {30'h0, isc_pkg::RESP_SLVERR}, {30'h0, resp});
      bus_write(12'h120, 32'h0000_00e0);
      rd_chk("enable", 12'h120, 32'h0000_00e0);
      bus_write(isc_pkg::OFF_CONTROL, 32'h0000_1300);
      chk("multi_vector_select", 32'h1, {31'h0, multi_vector_select});
      rd_chk("control", isc_pkg::OFF_CONTROL, 32'h0000_1300);
      // Source 7 has priority zero, source 8 is not enabled
      pulse_src(7);
      pulse_src(8);
      chk_pick(1'b0, 8'h00, 3'h0);
      rd_chk("flags", 12'h100, 32'h0000_0180);
      bus_write(12'h100, 32'h0);
      pulse_src(5);
      chk_pick(1'b1, 8'h05, 3'h3);
      chk("proximity loads", 32'd1, prox_cnt);
      rd_chk("status level", isc_pkg::OFF_STATUS, 32'h0000_0300);
      take_enable <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rd_chk("status serviced", isc_pkg::OFF_STATUS, 32'h0000_0305);
      take_enable <= 1'b0;
      chk("irq masked", 32'h0, {31'h0, irq});
      bus_write(isc_pkg::OFF_EVT_MASK, 32'h1);
      repeat (2) @(posedge ref_clk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      rd_chk("event status set", isc_pkg::OFF_EVT_STATUS, 32'h7);
      bus_write(isc_pkg::OFF_EVT_STATUS, 32'h7);
      repeat (2) @(posedge ref_clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd_chk("event status", isc_pkg::OFF_EVT_STATUS, 32'h0);
      // Level 4 is above threshold 3: no load
      bus_write(12'h100, 32'h0);
      pulse_src(6);
      chk_pick(1'b1, 8'h06, 3'h4);
      chk("no load above", 32'd1, prox_cnt);
      rd_chk("status level 4", isc_pkg::OFF_STATUS, 32'h0000_0405);
      // Single vector mode with the timer disabled
      bus_write(isc_pkg::OFF_CONTROL, 32'h0);
      bus_write(12'h100, 32'h0);
      pulse_src(5);
      chk_pick(1'b1, 8'h00, 3'h3);
      chk("multi_vector_select", 32'h0, {31'h0, multi_vector_select});
      chk("no load disabled", 32'd1, prox_cnt);
      bus_write(12'h120, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk("request_valid blocked", 32'h0, {31'h0, request_valid});
      conclude();
   end
endmodule
`default_nettype wire
